// ==== rtl/multidrop_serial_node.sv ====
// serial node of a drive on a multi-drop rs-422 chain: address, selection, echo, xon/xoff
// assumes rxd is synchronous to clk and idles high; the line driver honours txd_oe_n
// Function
// - the node address is the six switch bits, switch 1 the lsb and switch 6 the msb.
// - a node with address 1 to 63 waits until the host selects it before it takes part.
// - a node with address zero transmits without waiting to be selected.
// - the switch address is taken only at reset and later switch changes are ignored.
// - when the host selects address zero every node executes commands and none answers.
// - global selection holds until another address is selected, then only that node is.
// - runs full duplex and, while it may transmit, echoes accepted characters but select and xon/xoff to the host; of several held by xoff, only the last.
// - every frame has exactly one stop bit on both ends.
// - frames carry eight data bits by default, the host matching the node's width.
// - flow control is xon/xoff only, with no hardware handshake.
`timescale 1ns/1ns
module multidrop_serial_node #(
  parameter int unsigned BAUD_DIV  = node_link_pkg::BIT_CYCLES,
  parameter int unsigned DATA_BITS = node_link_pkg::DATA_BITS_DEFAULT
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  // address switches
  input  wire logic [node_link_pkg::ADDR_W-1:0]  node_address_switch_bank,
  // serial line
  input  wire logic                              rxd,
  output logic                                   txd,
  output logic                                   txd_oe_n,
  // received command characters
  output logic                                   rx_valid,
  output logic [7:0]                             rx_data,
  // response characters to send
  input  wire logic                              tx_valid,
  input  wire logic [7:0]                        tx_data,
  output logic                                   tx_ready,
  // status
  output logic [node_link_pkg::ADDR_W-1:0]       node_address,
  output logic                                   node_selected,
  output logic                                   global_selected,
  output logic                                   flow_paused
);
  localparam logic [node_link_pkg::CNT_W-1:0] DIV_LAST  =
    node_link_pkg::CNT_W'(BAUD_DIV - 1);
  localparam logic [node_link_pkg::CNT_W-1:0] HALF_LAST =
    node_link_pkg::CNT_W'(BAUD_DIV / 2 - 1);
  localparam logic [2:0] BIT_LAST = 3'(DATA_BITS - 1);

  function automatic logic is_select(input logic [7:0] b);
    is_select = b[node_link_pkg::SELECT_MSB:node_link_pkg::SELECT_LSB]
                == node_link_pkg::SELECT_MARK;
  endfunction

  node_link_pkg::link_state_t rx_state_reg, rx_state_next;
  node_link_pkg::link_state_t tx_state_reg, tx_state_next;
  node_link_pkg::sel_t        sel_reg, sel_next;
  logic [node_link_pkg::CNT_W-1:0] rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
  logic [2:0]  rx_bit_reg, rx_bit_next, tx_bit_reg, tx_bit_next;
  logic [7:0]  rx_shift_reg, rx_shift_next, tx_shift_reg, tx_shift_next;
  logic [5:0]  addr_reg, addr_next;
  logic        boot_reg, boot_next;
  logic        xoff_reg, xoff_next;
  logic        echo_pend_reg, echo_pend_next;
  logic [7:0]  echo_data_reg, echo_data_next;
  logic        rx_valid_reg, rx_valid_next;
  logic [7:0]  rx_data_reg, rx_data_next;
  logic        txd_reg, txd_next;
  logic        oe_n_reg, oe_n_next;
  logic [7:0]  fifo_mem [node_link_pkg::FIFO_DEPTH];
  logic        wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0]  count_reg, count_next;
  logic        tx_ready_reg, tx_ready_next;
  logic        byte_done, accepted, may_tx, push, pop;

  always_comb begin
    rx_state_next  = rx_state_reg;
    rx_cnt_next    = rx_cnt_reg + 1'b1;
    rx_bit_next    = rx_bit_reg;
    rx_shift_next  = rx_shift_reg;
    sel_next       = sel_reg;
    addr_next      = addr_reg;
    boot_next      = 1'b1;
    xoff_next      = xoff_reg;
    echo_pend_next = echo_pend_reg;
    echo_data_next = echo_data_reg;
    rx_valid_next  = 1'b0;
    rx_data_next   = rx_data_reg;
    tx_state_next  = tx_state_reg;
    tx_cnt_next    = tx_cnt_reg + 1'b1;
    tx_bit_next    = tx_bit_reg;
    tx_shift_next  = tx_shift_reg;
    txd_next       = txd_reg;
    rd_ptr_next    = rd_ptr_reg;
    wr_ptr_next    = wr_ptr_reg;
    byte_done      = 1'b0;
    pop            = 1'b0;
    // the switches are only looked at in the first cycle after reset
    if (!boot_reg) begin
      addr_next = node_address_switch_bank;
    end
    accepted = (addr_reg == node_link_pkg::ADDR_GLOBAL) ||
               sel_reg.selected || sel_reg.global_sel;
    // no driving before the switches are in, or a nonzero node would grab the line for a cycle
    may_tx   = boot_reg && !sel_reg.global_sel &&
               ((addr_reg == node_link_pkg::ADDR_GLOBAL) || sel_reg.selected);

    // receiver, one stop bit only
    case (rx_state_reg)
      node_link_pkg::LINK_IDLE: begin
        rx_cnt_next = '0;
        if (!rxd && boot_reg) begin
          rx_state_next = node_link_pkg::LINK_START;
          rx_shift_next = node_link_pkg::BYTE_ZERO;
        end
      end
      node_link_pkg::LINK_START: begin
        if (rx_cnt_reg == HALF_LAST) begin
          rx_cnt_next   = '0;
          rx_bit_next   = '0;
          rx_state_next = rxd ? node_link_pkg::LINK_IDLE : node_link_pkg::LINK_DATA;
        end
      end
      node_link_pkg::LINK_DATA: begin
        if (rx_cnt_reg == DIV_LAST) begin
          rx_cnt_next                = '0;
          rx_shift_next              = rx_shift_reg >> 1;
          rx_shift_next[DATA_BITS-1] = rxd;
          rx_bit_next                = rx_bit_reg + 1'b1;
          if (rx_bit_reg == BIT_LAST) begin
            rx_state_next = node_link_pkg::LINK_STOP;
          end
        end
      end
      node_link_pkg::LINK_STOP: begin
        if (rx_cnt_reg == DIV_LAST) begin
          rx_state_next = node_link_pkg::LINK_IDLE;
          byte_done     = rxd;
        end
      end
      default: rx_state_next = node_link_pkg::LINK_IDLE;
    endcase

    // transmitter; xoff holds back new characters, a frame in flight completes
    case (tx_state_reg)
      node_link_pkg::LINK_IDLE: begin
        txd_next    = 1'b1;
        tx_cnt_next = '0;
        if (may_tx && !xoff_reg) begin
          if (echo_pend_reg) begin
            tx_shift_next  = echo_data_reg;
            echo_pend_next = 1'b0;
            tx_state_next  = node_link_pkg::LINK_START;
            txd_next       = 1'b0;
          end else if (count_reg != 2'h0) begin
            tx_shift_next = fifo_mem[rd_ptr_reg];
            rd_ptr_next   = !rd_ptr_reg;
            pop           = 1'b1;
            tx_state_next = node_link_pkg::LINK_START;
            txd_next      = 1'b0;
          end
        end
      end
      node_link_pkg::LINK_START: begin
        if (tx_cnt_reg == DIV_LAST) begin
          tx_cnt_next   = '0;
          tx_bit_next   = '0;
          txd_next      = tx_shift_reg[0];
          tx_state_next = node_link_pkg::LINK_DATA;
        end
      end
      node_link_pkg::LINK_DATA: begin
        if (tx_cnt_reg == DIV_LAST) begin
          tx_cnt_next = '0;
          if (tx_bit_reg == BIT_LAST) begin
            txd_next      = 1'b1;
            tx_state_next = node_link_pkg::LINK_STOP;
          end else begin
            tx_shift_next = tx_shift_reg >> 1;
            txd_next      = tx_shift_reg[1];
            tx_bit_next   = tx_bit_reg + 1'b1;
          end
        end
      end
      node_link_pkg::LINK_STOP: begin
        if (tx_cnt_reg == DIV_LAST) begin
          tx_state_next = node_link_pkg::LINK_IDLE;
        end
      end
      default: tx_state_next = node_link_pkg::LINK_IDLE;
    endcase

    // character handling; the echo set comes after its clear so a new echo wins
    if (byte_done) begin
      if (is_select(rx_shift_reg)) begin
        sel_next.global_sel = rx_shift_reg[node_link_pkg::ADDR_W-1:0] ==
                              node_link_pkg::ADDR_GLOBAL;
        sel_next.selected   = (rx_shift_reg[node_link_pkg::ADDR_W-1:0] == addr_reg) &&
                              (addr_reg != node_link_pkg::ADDR_GLOBAL);
      end else if (accepted && rx_shift_reg == node_link_pkg::CHAR_XON) begin
        xoff_next = 1'b0;
      end else if (accepted && rx_shift_reg == node_link_pkg::CHAR_XOFF) begin
        xoff_next = 1'b1;
      end else if (accepted) begin
        rx_valid_next = 1'b1;
        rx_data_next  = rx_shift_reg;
        if (may_tx) begin
          echo_pend_next = 1'b1;
          echo_data_next = rx_shift_reg;
        end
      end
    end

    // two-entry buffer for response characters
    push = tx_valid && tx_ready_reg;
    if (push) begin
      wr_ptr_next = !wr_ptr_reg;
    end
    count_next    = count_reg + {1'b0, push} - {1'b0, pop};
    tx_ready_next = count_next != 2'(node_link_pkg::FIFO_DEPTH);
    // driver stays on until a frame already started has left the line
    oe_n_next = !(may_tx || (tx_state_next != node_link_pkg::LINK_IDLE));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state_reg  <= node_link_pkg::LINK_IDLE;
      tx_state_reg  <= node_link_pkg::LINK_IDLE;
      sel_reg       <= node_link_pkg::SEL_RESET;
      rx_cnt_reg    <= '0;
      tx_cnt_reg    <= '0;
      rx_bit_reg    <= '0;
      tx_bit_reg    <= '0;
      rx_shift_reg  <= node_link_pkg::BYTE_ZERO;
      tx_shift_reg  <= node_link_pkg::BYTE_ZERO;
      addr_reg      <= node_link_pkg::ADDR_GLOBAL;
      boot_reg      <= 1'b0;
      xoff_reg      <= 1'b0;
      echo_pend_reg <= 1'b0;
      echo_data_reg <= node_link_pkg::BYTE_ZERO;
      rx_valid_reg  <= 1'b0;
      rx_data_reg   <= node_link_pkg::BYTE_ZERO;
      txd_reg       <= 1'b1;
      oe_n_reg      <= 1'b1;
      wr_ptr_reg    <= 1'b0;
      rd_ptr_reg    <= 1'b0;
      count_reg     <= '0;
      tx_ready_reg  <= 1'b0;
    end else begin
      rx_state_reg  <= rx_state_next;
      tx_state_reg  <= tx_state_next;
      sel_reg       <= sel_next;
      rx_cnt_reg    <= rx_cnt_next;
      tx_cnt_reg    <= tx_cnt_next;
      rx_bit_reg    <= rx_bit_next;
      tx_bit_reg    <= tx_bit_next;
      rx_shift_reg  <= rx_shift_next;
      tx_shift_reg  <= tx_shift_next;
      addr_reg      <= addr_next;
      boot_reg      <= boot_next;
      xoff_reg      <= xoff_next;
      echo_pend_reg <= echo_pend_next;
      echo_data_reg <= echo_data_next;
      rx_valid_reg  <= rx_valid_next;
      rx_data_reg   <= rx_data_next;
      txd_reg       <= txd_next;
      oe_n_reg      <= oe_n_next;
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      tx_ready_reg  <= tx_ready_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= tx_data;
    end
  end

  assign txd             = txd_reg;
  assign txd_oe_n        = oe_n_reg;
  assign rx_valid        = rx_valid_reg;
  assign rx_data         = rx_data_reg;
  assign tx_ready        = tx_ready_reg;
  assign node_address    = addr_reg;
  assign node_selected   = sel_reg.selected;
  assign global_selected = sel_reg.global_sel;
  assign flow_paused     = xoff_reg;
endmodule

// ==== rtl/node_link_pkg.sv ====
// constants and carrier types for the multi-drop serial node
// assumes one 50 MHz clock and a synchronous active-high reset
package node_link_pkg;
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned BIT_CYCLES   = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned DATA_BITS_DEFAULT = 8;
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned FIFO_DEPTH   = 2;

  localparam logic [5:0] ADDR_GLOBAL   = 6'h00;
  localparam logic [1:0] SELECT_MARK   = 2'h2;
  localparam int unsigned SELECT_MSB   = 7;
  localparam int unsigned SELECT_LSB   = 6;
  localparam logic [7:0] CHAR_XON      = 8'h11;
  localparam logic [7:0] CHAR_XOFF     = 8'h13;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'h0,
    LINK_START = 2'h1,
    LINK_DATA  = 2'h3,
    LINK_STOP  = 2'h2
  } link_state_t;

  typedef struct packed {
    logic selected;
    logic global_sel;
  } sel_t;

  localparam sel_t SEL_RESET = '{selected: 1'b0, global_sel: 1'b0};
endpackage

// ==== testbench/host_terminal_model.sv ====
// host terminal on the shared rs-422 pair: sends characters, hears the line
// assumes the line floats high (mark) whenever no node drives it
`timescale 1ns/1ns
module host_terminal_model #(
  parameter int unsigned BAUD_DIV = 16
) (
  // clock
  input  wire logic clk,
  // shared line
  input  wire logic line_in,
  output logic      rxd_out
);
  logic [7:0]  heard_q[$];
  logic [7:0]  shift;
  int unsigned stop_errors;
  initial begin
    rxd_out = 1'b1;
    stop_errors = 0;
  end
  // bit time scaled down from the default rate to keep the run short
  // start, eight data lsb first, one stop, no parity; no rts/cts line exists
  // a low stop bit makes a broken frame; the line goes back to mark after every frame
  task automatic send_char(input logic [7:0] ch, input logic stop);
    logic [9:0] frame;
    frame = {stop, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd_out <= frame[i];
      repeat (BAUD_DIV - 1) @(posedge clk);
    end
    rxd_out <= 1'b1;
  endtask
  // mid-bit sampling; a low stop bit is counted, not dropped
  initial forever begin
    @(posedge clk iff line_in === 1'b0);
    repeat (BAUD_DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_DIV) @(posedge clk);
      shift[i] = line_in;
    end
    repeat (BAUD_DIV) @(posedge clk);
    if (line_in !== 1'b1) stop_errors++;
    heard_q.push_back(shift);
  end
endmodule

// ==== testbench/multidrop_serial_node_props.sv ====
// checker for the serial node: quiet line, selection, echo and flow control
// assumes it is bound to the node top and sees only its ports
`timescale 1ns/1ns
module node_link_checker #(
  parameter int unsigned BAUD_DIV = 16
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // line and streams
  input wire logic       txd,
  input wire logic       txd_oe_n,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       tx_ready,
  // status
  input wire logic [5:0] node_address,
  input wire logic       node_selected,
  input wire logic       global_selected,
  input wire logic       flow_paused
);
  logic [1:0]  up_reg;
  int unsigned mute_reg;
  int unsigned idle_reg;
  logic        mute;
  logic        allowed;
  assign mute = global_selected || (node_address != 6'h00 && !node_selected);
  assign allowed = !global_selected && !flow_paused && (node_address == 6'h00 || node_selected);
  // mute count waits past one frame, since a frame under way may finish
  always_ff @(posedge clk) begin
    up_reg   <= sys_rst ? 2'h0 : up_reg + {1'b0, up_reg != 2'h3};
    mute_reg <= (sys_rst || !mute) ? 0 : mute_reg + 1;
    idle_reg <= (sys_rst || !txd) ? 0 : idle_reg + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_echo_cause;
    rx_valid && rx_data[7:6] != 2'h2 && allowed && idle_reg > 10 * BAUD_DIV;
  endsequence
  sequence s_start_bit;
    !txd [*8];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> txd && txd_oe_n && !tx_ready)
    else $error("line not quiet in reset");
  a_boot_quiet: assert property ($fell(sys_rst) |-> txd_oe_n ##1 txd_oe_n)
    else $error("line driven before address taken");
  a_addr_hold: assert property (up_reg == 2'h3 |-> $stable(node_address))
    else $error("address moved while running");
  a_mute_quiet: assert property (mute_reg > 11 * BAUD_DIV |-> txd_oe_n)
    else $error("muted node drives line");
  a_idle_high: assert property (txd_oe_n |-> txd)
    else $error("released line not idle");
  a_echo_start: assert property (s_echo_cause |-> ##[1:2] s_start_bit)
    else $error("echo did not start");
  a_pulse_once: assert property (rx_valid |=> !rx_valid)
    else $error("rx_valid longer than one cycle");
  a_sel_excl: assert property (global_selected || node_address == 6'h00 |-> !node_selected)
    else $error("selected beside global or zero");
  a_xoff_eaten: assert property ($rose(flow_paused) |-> !rx_valid ##1 !rx_valid)
    else $error("xoff passed on");
endmodule

// ==== testbench/multidrop_serial_node_test.sv ====
// self-checking bench for the multi-drop serial node
// assumes the host model drives rxd and hears the line, high when undriven
`timescale 1ns/1ns
module multidrop_serial_node_test;
  localparam int unsigned DIV = 16;
  logic       clk, sys_rst, tx_valid, rxd, txd, txd_oe_n, line, rx_valid, tx_ready, ok;
  logic       node_selected, global_selected, flow_paused;
  logic [5:0] sw, node_address, a;
  logic [7:0] tx_data, rx_data, c, b0, b1;
  int         num_errors, samples_checked, rx_count, n, k, seed;
  always #10 clk = ~clk;
  assign line = txd_oe_n ? 1'b1 : txd;
  always @(posedge clk) if (rx_valid === 1'b1) rx_count++;
  multidrop_serial_node #(.BAUD_DIV(DIV), .DATA_BITS(8)) u_multidrop_serial_node (
    .clk(clk), .sys_rst(sys_rst), .node_address_switch_bank(sw), .rxd(rxd), .txd(txd),
    .txd_oe_n(txd_oe_n), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .node_address(node_address),
    .node_selected(node_selected), .global_selected(global_selected), .flow_paused(flow_paused));
  host_terminal_model #(.BAUD_DIV(DIV)) u_host_terminal_model (
    .clk(clk), .line_in(line), .rxd_out(rxd));
  function automatic logic [7:0] heard(int back);
    return u_host_terminal_model.heard_q[$ - back];
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic restart(input logic [5:0] v);
    sys_rst <= 1'b1;
    sw <= v;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // a frame plus the echo frame it may cause
  task automatic send(input logic [7:0] ch);
    u_host_terminal_model.send_char(ch, 1'b1);
    repeat (12 * DIV) @(posedge clk);
  endtask
  task automatic offer(input logic [7:0] b, output logic taken);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data <= b;
    taken = 1'b0;
    for (int i = 0; i < 4 && !taken; i++) begin
      @(posedge clk);
      taken = (tx_ready === 1'b1);
    end
    tx_valid <= 1'b0;
  endtask
  function automatic logic [7:0] pick();
    return 8'h40 | 8'($random(seed) & 32'h0000_003f);
  endfunction
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    sw = 6'h00;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    num_errors = 0;
    samples_checked = 0;
    rx_count = 0;
    seed = 32'h3efe_9bce;
    restart(6'h00);
    check("oe_addr0", 8'(txd_oe_n), 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = pick();
      send(c);
      check("rx_data", rx_data, c);
      check("echo", heard(0), c);
    end
    k = rx_count;
    n = u_host_terminal_model.heard_q.size();
    u_host_terminal_model.send_char(pick(), 1'b0);
    repeat (12 * DIV) @(posedge clk);
    check("bad_stop", 8'(rx_count - k), 8'h00);
    check("bad_echo", 8'(u_host_terminal_model.heard_q.size() - n), 8'h00);
    $display("test echo done");
    k = rx_count;
    send(8'h13);
    check("paused", {flow_paused, 7'(rx_count - k)}, 8'h80);
    n = u_host_terminal_model.heard_q.size();
    c = pick();
    send(c);
    check("held", 8'(u_host_terminal_model.heard_q.size() - n), 8'h00);
    send(8'h11);
    check("resumed", {7'h00, flow_paused}, 8'h00);
    check("late_echo", heard(0), c);
    $display("test flow done");
    send(8'h80);
    check("global", 8'(global_selected), 8'h01);
    n = u_host_terminal_model.heard_q.size();
    k = rx_count;
    send(pick());
    check("gl_exec", 8'(rx_count - k), 8'h01);
    check("gl_quiet", 8'(u_host_terminal_model.heard_q.size() - n), 8'h00);
    $display("test global done");
    a = 6'($random(seed));
    if (a == 6'h00) a = 6'h01;
    restart(a);
    sw <= ~a;
    repeat (4) @(posedge clk);
    check("address", 8'(node_address), 8'(a));
    check("oe_unsel", 8'(txd_oe_n), 8'h01);
    k = rx_count;
    send(pick());
    check("unsel_rx", 8'(rx_count - k), 8'h00);
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    offer(b0, ok);
    check("take0", 8'(ok), 8'h01);
    offer(b1, ok);
    check("take1", 8'(ok), 8'h01);
    offer(pick(), ok);
    check("full", 8'(ok), 8'h00);
    send(8'h80 | 8'(a));
    check("selected", 8'(node_selected), 8'h01);
    repeat (24 * DIV) @(posedge clk);
    check("drain0", heard(1), b0);
    check("drain1", heard(0), b1);
    c = pick();
    send(c);
    check("sel_echo", heard(0), c);
    send(8'h80 | 8'(a == 6'h3f ? 6'h3e : a + 6'h01));
    check("other", 8'(node_selected), 8'h00);
    send(8'h80);
    send(8'h80 | 8'(a));
    check("reselect", {node_selected, global_selected, 6'h00}, 8'h80);
    check("stop_bits", 8'(u_host_terminal_model.stop_errors), 8'h00);
    $display("test select done");
    conclude();
  end
endmodule
bind multidrop_serial_node node_link_checker #(.BAUD_DIV(BAUD_DIV)) u_node_link_checker (
  .clk(clk), .sys_rst(sys_rst), .txd(txd), .txd_oe_n(txd_oe_n), .rx_valid(rx_valid),
  .rx_data(rx_data), .tx_ready(tx_ready), .node_address(node_address),
  .node_selected(node_selected), .global_selected(global_selected), .flow_paused(flow_paused));
